//--- bench/rsc_monitor.sv
// Checker for the segment controller: bus handshakes and ramp freeze
`timescale 1ns/1ps
module rsc_monitor
  import rsc_pkg::*;
(
  input wire logic        mclk,            // Clock
  input wire logic        arst_n,          // Reset, active low
  input wire logic [11:0] s_axi_awaddr,    // Write address
  input wire logic        s_axi_awvalid,   // Address valid
  input wire logic        s_axi_awready,   // Address ready
  input wire logic [31:0] s_axi_wdata,     // Write data
  input wire logic        s_axi_wvalid,    // Data valid
  input wire logic        s_axi_wready,    // Data ready
  input wire logic [1:0]  s_axi_bresp,     // Write response
  input wire logic        s_axi_bvalid,    // Response valid
  input wire logic        s_axi_bready,    // Response ready
  input wire logic        s_axi_arvalid,   // Read address valid
  input wire logic        s_axi_arready,   // Read address ready
  input wire logic [31:0] s_axi_rdata,     // Read data
  input wire logic        s_axi_rvalid,    // Read valid
  input wire logic        s_axi_rready,    // Read ready
  input wire logic [32:0] ramp_acc,        // Accumulator
  input wire logic        fast_settle_on,  // Fastlock
  input wire logic        marker_out_low,  // Marker 0
  input wire logic        marker_out_high  // Marker 1
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Answers stand until taken; a busy slave refuses new requests
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  // Commit happens the cycle after the beats are taken, response one edge later
  property p_b_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid; endproperty
  a_b_lat: assert property (p_b_lat) else $error("write response late");
  property p_r_lat; s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read data late");
  property p_b_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken while busy");
  property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_r_busy: assert property (p_r_busy) else $error("read taken while busy");
  // Outputs quiet at first edge after reset
  property p_rst; $rose(arst_n) |-> ramp_acc == 33'h0_0000_0000 && !fast_settle_on
    && !marker_out_low && !marker_out_high && s_axi_awready; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  // Stopping the run freezes the accumulator
  property p_stop; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr == ADDR_CTRL && !s_axi_wdata[0] |-> ##4 $stable(ramp_acc) [*4]; endproperty
  a_stop: assert property (p_stop) else $error("accumulator moves when stopped");

  // Main scenarios reached
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_mk: cover property (marker_out_low && marker_out_high);
  c_fs: cover property (fast_settle_on);
endmodule

bind rsc_top rsc_monitor u_mon (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ramp_acc,
  .fast_settle_on, .marker_out_low, .marker_out_high);

//--- bench/tb.sv
// Self-checking bench for the ramp segment controller
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import rsc_pkg::*;
  logic        mclk, arst_n;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0]  trg;
  logic [32:0] ramp_acc;
  logic        fast_settle_on, marker_out_low, marker_out_high;
  int          mismatches, n_tests;

  rsc_top u_dut (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .trig_a(trg[0]), .trig_b(trg[1]), .trig_c(trg[2]), .ramp_acc,
    .fast_settle_on, .marker_out_low, .marker_out_high);

  // Bus write: address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rresp, er)
    `CHK(s_axi_rdata, ed)
  endtask

  task automatic seg(input int n, input logic [31:0] st, input logic [31:0] ln,
                     input logic [31:0] ct);
    wr(SEG_BASE + SEG_STRIDE * 12'(n) + {8'h00, OFF_STEP}, st, RESP_OKAY);
    wr(SEG_BASE + SEG_STRIDE * 12'(n) + {8'h00, OFF_LEN}, ln, RESP_OKAY);
    wr(SEG_BASE + SEG_STRIDE * 12'(n) + {8'h00, OFF_CTRL}, ct, RESP_OKAY);
  endtask

  // Bounded wait for a marker pattern, stops at its first cycle
  task automatic wait_mark(input logic [1:0] m);
    int i;
    for (i = 0; i < 20 && {marker_out_high, marker_out_low} !== m; i++)
      @(posedge mclk);
    `CHK({marker_out_high, marker_out_low}, m)
  endtask

  task automatic t_reset;
    `CHK({ramp_acc, fast_settle_on, marker_out_low, marker_out_high}, 36'h0_0000_0000)
    rd(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    rd(ADDR_ACC, 32'h0000_0000, RESP_OKAY);
    rd(SEG_BASE, 32'h0000_0000, RESP_SLVERR);
    wr(12'hFFC, 32'h0000_0001, RESP_SLVERR);
    rd(12'hFFC, 32'h0000_0000, RESP_SLVERR);
  endtask

  // Three-segment loop: lengths, half rate, markers, fast settle, clear
  task automatic t_loop;
    int          r, j, k;
    int          cyc[3] = '{3, 4, 1};
    logic [32:0] dl[2] = '{33'h0_0000_000F, 33'h1_FFFF_FFFC};
    logic [32:0] a0, sa;
    seg(0, 32'h0000_0005, 32'h0000_0003, 32'h0000_0116);
    seg(1, 32'h3FFF_FFFE, 32'h0000_0002, 32'h0000_0221);
    seg(2, 32'h0000_0001, 32'h0000_0001, 32'h0000_0030);
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    wait_mark(2'h3);
    wait_mark(2'h1);
    a0 = ramp_acc;
    for (r = 0; r < 2; r++) begin
      for (j = 0; j < 3; j++) begin
        sa = ramp_acc;
        for (k = 0; k < cyc[j]; k++) begin
          `CHK({marker_out_high, marker_out_low}, 2'(j + 1))
          `CHK(fast_settle_on, 1'(j == 0))
          @(posedge mclk);
        end
        if (j < 2) `CHK(ramp_acc - sa, dl[j])
      end
      `CHK(ramp_acc, a0)
    end
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    repeat (2) @(posedge mclk);
    sa = ramp_acc;
    repeat (5) @(posedge mclk);
    `CHK(ramp_acc, sa)
  endtask

  // Trigger advance: wrong triggers ignored, own trigger moves on
  task automatic t_trig;
    int k;
    for (k = 0; k < 3; k++)
      seg(k, 32'h0000_0001, 32'h0000_0000, 32'((k + 1) * 'h50 + ((k + 1) % 3) * 'h100));
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    wait_mark(2'h1);
    for (k = 0; k < 3; k++) begin
      trg <= 3'b111 & ~(3'b001 << k);
      @(posedge mclk);
      trg <= 3'b000;
      repeat (3) @(posedge mclk);
      `CHK({marker_out_high, marker_out_low}, 2'(k + 1))
      rd(ADDR_STATUS, 32'((k + 1) << 7 | k << 4 | 1), RESP_OKAY);
      trg <= 3'b001 << k;
      @(posedge mclk);
      trg <= 3'b000;
      wait_mark(2'((k + 1) % 3 + 1));
    end
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Main sequence
  initial begin
    {arst_n, s_axi_awaddr, s_axi_araddr, s_axi_wdata, trg} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset;
    t_loop;
    t_trig;
    wrap_up;
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    mismatches++;
    $display("ERROR t=%0t watchdog expired", $time);
    wrap_up;
  end
endmodule

//--- logic/rsc_pkg.sv
// Package: ramp segment control constants, register map and types
package rsc_pkg;
  localparam int          SEG_NUM      = 8;
  localparam int          STEP_W       = 30;
  localparam int          LEN_W        = 16;
  localparam int          ACC_W        = 33;
  // Segment register map: base + 16 bytes per segment
  localparam logic [11:0] SEG_BASE     = 12'h100;
  localparam logic [11:0] SEG_STRIDE   = 12'h010;
  localparam logic [3:0]  OFF_STEP     = 4'h0;
  localparam logic [3:0]  OFF_LEN      = 4'h4;
  localparam logic [3:0]  OFF_CTRL     = 4'h8;
  // Global registers
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_ACC     = 12'h008;
  // Field positions in segment control word
  localparam int          CB_HALF      = 0;
  localparam int          CB_FAST      = 1;
  localparam int          CB_CLR       = 2;
  localparam int          CB_MRK       = 4;
  localparam int          CB_SRC       = 6;
  localparam int          CB_SUCC      = 8;
  localparam logic [1:0]  SRC_LEN      = 2'h0;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  typedef enum logic [1:0] {RSC_IDLE = 2'b00, RSC_RUN = 2'b01} rsc_state_e;
endpackage

//--- logic/rsc_seg_mem.sv
// Segment settings memory: one word per segment, registered read port
`timescale 1ns/1ps
module rsc_seg_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 32
) (
  input  wire logic                     mclk,    // Compare-rate clock
  input  wire logic                     arst_n,  // Async reset, active low
  input  wire logic                     wr_en,   // Write strobe
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr, // Write index
  input  wire logic [WIDTH-1:0]         wr_data, // Write data
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr, // Read index
  output logic      [WIDTH-1:0]         rd_data  // Registered read data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [WIDTH-1:0] rd_next;

  // Index port needs at least one bit
  if (DEPTH < 2 || WIDTH < 1) begin : g_size_chk
    $error("rsc_seg_mem needs DEPTH of two or more and WIDTH of one or more");
  end

  // Next-state for array and read port
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (wr_en) begin
      mem_next[wr_addr] = wr_data;
    end
    rd_next = mem_reg[rd_addr];
  end

  // Fields power up as zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      rd_data <= '0;
    end else begin
      mem_reg <= mem_next;
      rd_data <= rd_next;
    end
  end
endmodule

//--- logic/rsc_top.sv
// Ramp segment controls: eight segments, ramp accumulator, AXI4-Lite slave
// Summary of operation
// RQ1 - Eight segments, each with own settings
// RQ2 - Add signed step each tick, length ticks
// RQ3 - Half-rate bit makes tick two cycles
// RQ4 - Fast-settle bit enables fastlock while running
// RQ5 - Marker bits driven out at segment start
// RQ6 - Clear bit zeroes accumulator at start
// RQ7 - Advance on length expiry or trigger
// RQ8 - Successor field picks next segment
// RQ9 - Load successor settings with no idle
`timescale 1ns/1ps
module rsc_top
  import rsc_pkg::*;
#(
  parameter int SEGS = rsc_pkg::SEG_NUM
) (
  input  wire logic        mclk,            // Compare-rate clock, 125 MHz
  input  wire logic        arst_n,          // Async reset, active low
  input  wire logic [11:0] s_axi_awaddr,    // Write address
  input  wire logic        s_axi_awvalid,   // Write address valid
  output logic             s_axi_awready,   // Write address ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
  input  wire logic        s_axi_wvalid,    // Write data valid
  output logic             s_axi_wready,    // Write data ready
  output logic [1:0]       s_axi_bresp,     // Write response
  output logic             s_axi_bvalid,    // Write response valid
  input  wire logic        s_axi_bready,    // Write response ready
  input  wire logic [11:0] s_axi_araddr,    // Read address
  input  wire logic        s_axi_arvalid,   // Read address valid
  output logic             s_axi_arready,   // Read address ready
  output logic [31:0]      s_axi_rdata,     // Read data
  output logic [1:0]       s_axi_rresp,     // Read response
  output logic             s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read ready
  input  wire logic        trig_a,          // Trigger A level
  input  wire logic        trig_b,          // Trigger B level
  input  wire logic        trig_c,          // Trigger C level
  output logic [32:0]      ramp_acc,        // Ramp accumulator
  output logic             fast_settle_on,  // Fastlock and slip reduction
  output logic             marker_out_low,  // Marker 0
  output logic             marker_out_high  // Marker 1
);
  import rsc_pkg::*;

  // Segment index fields are three bits wide, so only eight segments fit
  if (SEGS != 8) begin : g_seg_chk
    $error("rsc_top supports exactly eight segments");
  end

  // Per-segment word layout: 3 words per segment packed into three memories
  logic [31:0] step_q, len_q, ctrl_q;
  logic        we_step, we_len, we_ctrl;
  logic [2:0]  wr_seg, rd_seg;

  // Active segment settings
  logic [STEP_W-1:0] step_reg, step_next;
  logic [LEN_W:0]    left_reg, left_next;
  logic              half_reg, half_next;
  logic              phase_reg, phase_next;
  logic [1:0]        src_reg, src_next;
  logic [2:0]        succ_reg, succ_next;
  logic [2:0]        seg_reg, seg_next;
  logic [ACC_W-1:0]  acc_reg, acc_next;
  logic              fast_reg, fast_next;
  logic [1:0]        mrk_reg, mrk_next;
  logic              pend_reg, pend_next;
  rsc_state_e        st_reg, st_next;
  logic              en_reg, en_next;

  // Bus write and read side state
  logic              aw_ok_reg, aw_ok_next, w_ok_reg, w_ok_next;
  logic [11:0]       awa_reg, awa_next;
  logic [31:0]       wd_reg, wd_next;
  logic              bv_reg, bv_next;
  logic [1:0]        br_reg, br_next;
  logic              rv_reg, rv_next;
  logic [1:0]        rr_reg, rr_next;
  logic [31:0]       rd_reg, rd_next;
  logic              rd_wait_reg, rd_wait_next;
  logic [11:0]       ara_reg, ara_next;

  function automatic logic seg_hit(input logic [11:0] a);
    return (a >= SEG_BASE) && (a < SEG_BASE + 12'(SEGS) * SEG_STRIDE) && (a[1:0] == 2'b00)
      && (a[3:0] <= OFF_CTRL);
  endfunction

  function automatic logic [2:0] seg_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - SEG_BASE;
    return d[6:4];
  endfunction

  // Segment settings, one memory per word kind [RQ1]
  rsc_seg_mem #(.DEPTH(8), .WIDTH(32)) u_step (
    .mclk(mclk), .arst_n(arst_n), .wr_en(we_step), .wr_addr(wr_seg),
    .wr_data(wd_reg), .rd_addr(rd_seg), .rd_data(step_q));
  rsc_seg_mem #(.DEPTH(8), .WIDTH(32)) u_len (
    .mclk(mclk), .arst_n(arst_n), .wr_en(we_len), .wr_addr(wr_seg),
    .wr_data(wd_reg), .rd_addr(rd_seg), .rd_data(len_q));
  rsc_seg_mem #(.DEPTH(8), .WIDTH(32)) u_ctrl (
    .mclk(mclk), .arst_n(arst_n), .wr_en(we_ctrl), .wr_addr(wr_seg),
    .wr_data(wd_reg), .rd_addr(rd_seg), .rd_data(ctrl_q));

  // Read index follows next-state values so the successor word is ready one
  // edge after a load; a one-tick segment would otherwise reload stale settings [RQ9]
  assign rd_seg = (st_next == RSC_IDLE) ? 3'h0 : succ_next;
  assign wr_seg = seg_idx(awa_reg);

  // Write commits once both address and data are held
  logic wr_go;
  assign wr_go   = aw_ok_reg && w_ok_reg && !bv_reg;
  assign we_step = wr_go && seg_hit(awa_reg) && awa_reg[3:0] == OFF_STEP;
  assign we_len  = wr_go && seg_hit(awa_reg) && awa_reg[3:0] == OFF_LEN;
  assign we_ctrl = wr_go && seg_hit(awa_reg) && awa_reg[3:0] == OFF_CTRL;

  // AXI4-Lite write and read channels
  always_comb begin
    aw_ok_next = aw_ok_reg;
    w_ok_next  = w_ok_reg;
    awa_next   = awa_reg;
    wd_next    = wd_reg;
    bv_next    = bv_reg;
    br_next    = br_reg;
    en_next    = en_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_ok_next = 1'b1;
      awa_next   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_ok_next = 1'b1;
      // Byte lanes ignored: every field is whole-word; partial writes still commit
      wd_next   = s_axi_wdata;
    end
    if (wr_go) begin
      aw_ok_next = 1'b0;
      w_ok_next  = 1'b0;
      bv_next    = 1'b1;
      br_next    = RESP_OKAY;
      if (awa_reg == ADDR_CTRL) begin
        en_next = wd_reg[0];
      end else if (!seg_hit(awa_reg) && awa_reg != ADDR_STATUS && awa_reg != ADDR_ACC) begin
        br_next = RESP_SLVERR;
      end
    end
    if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    // Reads: one wait cycle before the answer; segment words read back as errors
    rv_next      = rv_reg;
    rr_next      = rr_reg;
    rd_next      = rd_reg;
    ara_next     = ara_reg;
    rd_wait_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      ara_next     = s_axi_araddr;
      rd_wait_next = 1'b1;
    end
    if (rd_wait_reg) begin
      rv_next = 1'b1;
      rr_next = RESP_OKAY;
      unique case (1'b1)
        ara_reg == ADDR_CTRL:   rd_next = {31'h0, en_reg};
        ara_reg == ADDR_STATUS: rd_next = {22'h0, fast_reg, mrk_reg, seg_reg, 3'h0,
                                           st_reg == RSC_RUN};
        ara_reg == ADDR_ACC:    rd_next = {31'h0, acc_reg[32]};
        default: begin
          rd_next = RESET_WORD;
          rr_next = RESP_SLVERR;
        end
      endcase
    end
    if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
  end

  assign s_axi_awready = !aw_ok_reg && !bv_reg;
  assign s_axi_wready  = !w_ok_reg && !bv_reg;
  assign s_axi_arready = !rv_reg && !rd_wait_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rresp   = rr_reg;
  assign s_axi_rdata   = rd_reg;

  // Ramp engine: tick, segment end and reload
  logic tick, trig_sel, seg_end;
  always_comb begin
    tick = !half_reg || phase_reg; // [RQ3]
    unique case (src_reg) // [RQ7]
      2'd1:    trig_sel = trig_a;
      2'd2:    trig_sel = trig_b;
      2'd3:    trig_sel = trig_c;
      default: trig_sel = tick && left_reg == (LEN_W+1)'(1);
    endcase
    seg_end = trig_sel;
  end

  always_comb begin
    st_next    = st_reg;
    step_next  = step_reg;
    left_next  = left_reg;
    half_next  = half_reg;
    phase_next = phase_reg;
    src_next   = src_reg;
    succ_next  = succ_reg;
    seg_next   = seg_reg;
    acc_next   = acc_reg;
    fast_next  = fast_reg;
    mrk_next   = mrk_reg;
    pend_next  = 1'b0;
    unique case (st_reg)
      RSC_IDLE: begin
        fast_next = 1'b0;
        // Settings of segment 0 appear a cycle after request; then start
        if (en_reg) begin
          pend_next = 1'b1;
        end
        if (pend_reg && en_reg) begin
          st_next = RSC_RUN;
          seg_next = 3'h0;
        end
      end
      RSC_RUN: begin
        if (tick) begin
          acc_next  = acc_reg + ACC_W'(signed'(step_reg)); // [RQ2]
          left_next = left_reg - (LEN_W+1)'(1);
        end
        phase_next = half_reg ? !phase_reg : 1'b0;
        if (!en_reg) begin
          st_next = RSC_IDLE;
        end else if (seg_end) begin
          seg_next = succ_reg; // [RQ8]
        end
      end
      default: st_next = RSC_IDLE;
    endcase
    // Load next segment at boundary, no idle tick [RQ9]
    if ((st_reg == RSC_IDLE && pend_reg && en_reg) || (st_reg == RSC_RUN && en_reg && seg_end))
    begin
      step_next  = step_q[STEP_W-1:0];
      // Zero length field means 65536 ticks [RQ2]
      left_next  = (len_q[LEN_W-1:0] == '0) ? (LEN_W+1)'(1 << LEN_W)
                                             : {1'b0, len_q[LEN_W-1:0]};
      half_next  = ctrl_q[CB_HALF]; // [RQ3]
      phase_next = 1'b0;
      fast_next  = ctrl_q[CB_FAST]; // [RQ4]
      mrk_next   = ctrl_q[CB_MRK +: 2]; // [RQ5]
      src_next   = ctrl_q[CB_SRC +: 2];
      succ_next  = ctrl_q[CB_SUCC +: 3];
      if (ctrl_q[CB_CLR]) begin
        acc_next = '0; // [RQ6]
      end
    end
  end

  // Register all state
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= RSC_IDLE; step_reg <= '0; left_reg <= '0; half_reg <= 1'b0;
      phase_reg <= 1'b0; src_reg <= SRC_LEN; succ_reg <= '0; seg_reg <= '0;
      acc_reg <= '0; fast_reg <= 1'b0; mrk_reg <= '0; pend_reg <= 1'b0;
      en_reg <= 1'b0; aw_ok_reg <= 1'b0; w_ok_reg <= 1'b0; awa_reg <= '0;
      wd_reg <= '0; bv_reg <= 1'b0; br_reg <= RESP_OKAY; rv_reg <= 1'b0;
      rr_reg <= RESP_OKAY; rd_reg <= '0; rd_wait_reg <= 1'b0; ara_reg <= '0;
    end else begin
      st_reg <= st_next; step_reg <= step_next; left_reg <= left_next;
      half_reg <= half_next; phase_reg <= phase_next; src_reg <= src_next;
      succ_reg <= succ_next; seg_reg <= seg_next; acc_reg <= acc_next;
      fast_reg <= fast_next; mrk_reg <= mrk_next; pend_reg <= pend_next;
      en_reg <= en_next; aw_ok_reg <= aw_ok_next; w_ok_reg <= w_ok_next;
      awa_reg <= awa_next; wd_reg <= wd_next; bv_reg <= bv_next; br_reg <= br_next;
      rv_reg <= rv_next; rr_reg <= rr_next; rd_reg <= rd_next;
      rd_wait_reg <= rd_wait_next; ara_reg <= ara_next;
    end
  end

  assign ramp_acc        = acc_reg;
  assign fast_settle_on  = fast_reg; // [RQ4]
  assign marker_out_low  = mrk_reg[0]; // [RQ5]
  assign marker_out_high = mrk_reg[1]; // [RQ5]
endmodule
